// *** include/dma_controller_params.svh ***
// constants of the multichannel dma controller and its request router
// Behaviour
// - each transfer reads source then writes destination
// - software programs source, destination and size
// - larger instance: sixteen channels, sixty-four sources
// - smaller instance: eight channels, thirty-two sources
// - internal buffer holds up to 32 bytes
// - one 32-byte descriptor per channel inside
// - minor byte loop nested in major iterations
// - start by software, link or hardware request
// - completion of one channel may start another
// - one peripheral paced request line per channel
// - fixed priority or round robin arbitration
// - per channel interrupt at major completion
// - error stops channel, errors ored to one
// - scatter gather loads next descriptor from memory
// - one selectable router per channel, any slot
// - router forwards exactly one selected slot
// - routing change resets that channel's state
// - channels zero to three periodically triggerable
// - asynchronous requests can raise a wake request
`ifndef DMA_CONTROLLER_PARAMS_SVH
`define DMA_CONTROLLER_PARAMS_SVH
`define CH_COUNT 16
`define SLOT_COUNT 64
`define SMALL_CH_MASK 16'h00ff
`define SMALL_SLOT_MASK 6'h1f
`define DESC_WORDS 8
`define BUF_WORDS 4'h8
`define PERIODIC_CHANNELS 4
`define REG_ROUTE_BASE 12'h200
`define REG_CTRL 12'h300
`define REG_START 12'h304
`define REG_DONE 12'h308
`define REG_ERR 12'h30c
`define REG_ACTIVE 12'h310
`define DESC_SRC 3'h0
`define DESC_DST 3'h1
`define DESC_MINOR 3'h2
`define DESC_ITER 3'h3
`define DESC_CTRL 3'h4
`define DESC_SG 3'h5
`define CTRL_INT_MAJOR 0
`define CTRL_LINK_EN 1
`define CTRL_SG_EN 8
`define CTRL_ERR_EN 9
`define ROUTE_PERIODIC 6
`define ROUTE_ENABLE 7
`define ASYNC_SLOT_MASK 64'hffff_ffff_ffff_ffff
`endif

// *** include/dma_controller_pkg.sv ***
// types of the multichannel dma controller
`include "dma_controller_params.svh"
package dma_controller_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_READ = 3'h1,
      ST_WRITE = 3'h3,
      ST_NEXT = 3'h2,
      ST_SG = 3'h6
   } dma_state_t;
   typedef struct packed {
      dma_state_t state;
      logic [`CH_COUNT-1:0][`DESC_WORDS-1:0][31:0] desc;
      logic [7:0][31:0] buffer;
      logic [`CH_COUNT-1:0][7:0] route;
      logic [3:0] ch;
      logic [3:0] last;
      logic [2:0] idx;
      logic [3:0] cnt;
      logic [15:0] left;
      logic [15:0] pending;
      logic [15:0] done;
      logic [15:0] err;
      logic round_robin;
      logic [63:0] slot_s1;
      logic [63:0] slot_s2;
      logic [3:0] trig_s1;
      logic [3:0] trig_s2;
      logic [3:0] trig_s3;
      logic bus_req;
      logic bus_write;
      logic [31:0] bus_addr;
      logic [31:0] bus_wdata;
      logic [31:0] rdata;
      logic [15:0] ch_irq;
      logic err_irq;
      logic wake;
   } dma_regs_t;
endpackage

// *** verilog/dma_controller.sv ***
// multichannel dma controller with request router, registers and bus master
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dma_controller_params.svh"
module dma_controller #(
   parameter bit small_inst = 1'b0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [63:0] slot_req,
   input wire logic [3:0] periodic_trig,
   output logic bus_req,
   output logic bus_write,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic bus_err,
   input wire logic [31:0] bus_rdata,
   output logic [15:0] ch_irq,
   output logic err_irq,
   output logic wake_req
);
   dma_controller_pkg::dma_regs_t r;
   dma_controller_pkg::dma_regs_t n;

   // ==========================================================
   // arbitration
   function automatic logic [3:0] pick(input logic [15:0] p, input logic [3:0] last, input logic rr);
      logic [3:0] k;
      logic [3:0] sel;
      logic found;
      sel = 4'h0;
      found = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         k = rr ? 4'(last + 4'h1 + 4'(i)) : 4'(i);
         if (!found && p[k])
         begin
            sel = k;
            found = 1'b1;
         end
      end
      return sel;
   endfunction

   logic [15:0] ch_mask;
   assign ch_mask = small_inst ? `SMALL_CH_MASK : 16'hffff;

   // ==========================================================
   // next state
   always_comb
   begin
      logic [15:0] start;
      logic [15:0] clr_done;
      logic [15:0] clr_err;
      logic [15:0] set_done;
      logic [15:0] set_err;
      logic [15:0] rst;
      logic [15:0] hwreq;
      logic [15:0] link;
      logic [15:0] grab;
      logic [15:0] busy;
      logic [63:0] sel_slots;
      logic [3:0] trig_rise;
      logic [5:0] slot;
      logic [3:0] w;
      logic [31:0] ctl;
      start = 16'h0;
      clr_done = 16'h0;
      clr_err = 16'h0;
      set_done = 16'h0;
      set_err = 16'h0;
      rst = 16'h0;
      hwreq = 16'h0;
      link = 16'h0;
      grab = 16'h0;
      busy = 16'h0;
      sel_slots = 64'h0;
      slot = 6'h0;
      w = 4'h0;
      ctl = r.desc[r.ch][`DESC_CTRL];
      n = r;
      n.slot_s1 = slot_req;
      n.slot_s2 = r.slot_s1;
      n.trig_s1 = periodic_trig;
      n.trig_s2 = r.trig_s1;
      n.trig_s3 = r.trig_s2;
      trig_rise = r.trig_s2 & ~r.trig_s3;
      n.rdata = 32'h0;
      // register writes
      if (reg_wr)
      begin
         if (reg_addr < `REG_ROUTE_BASE)
            n.desc[reg_addr[8:5]][reg_addr[4:2]] = reg_wdata;
         else if (reg_addr[11:6] == 6'h08)
         begin
            n.route[reg_addr[5:2]] = reg_wdata[7:0];
            if (reg_wdata[7:0] != r.route[reg_addr[5:2]])
               rst[reg_addr[5:2]] = 1'b1;
         end
         else
         begin
            unique case (reg_addr)
               `REG_CTRL: n.round_robin = reg_wdata[0];
               `REG_START: start = reg_wdata[15:0];
               `REG_DONE: clr_done = reg_wdata[15:0];
               `REG_ERR: clr_err = reg_wdata[15:0];
               default: ;
            endcase
         end
      end
      // register reads, data stands in the next cycle
      if (reg_rd)
      begin
         if (reg_addr < `REG_ROUTE_BASE)
            n.rdata = r.desc[reg_addr[8:5]][reg_addr[4:2]];
         else if (reg_addr[11:6] == 6'h08)
            n.rdata = {24'h0, r.route[reg_addr[5:2]]};
         else
         begin
            unique case (reg_addr)
               `REG_CTRL: n.rdata = {31'h0, r.round_robin};
               `REG_DONE: n.rdata = {16'h0, r.done};
               `REG_ERR: n.rdata = {16'h0, r.err};
               `REG_ACTIVE: n.rdata = {11'h0, r.state != dma_controller_pkg::ST_IDLE, r.ch, r.pending};
               default: n.rdata = 32'h0;
            endcase
         end
      end
      // request router
      if (r.state != dma_controller_pkg::ST_IDLE)
         busy[r.ch] = 1'b1;
      for (int i = 0; i < `CH_COUNT; i++)
      begin
         slot = small_inst ? (r.route[i][5:0] & `SMALL_SLOT_MASK) : r.route[i][5:0];
         if (r.route[i][`ROUTE_ENABLE])
         begin
            sel_slots[slot] = 1'b1;
            if (i < `PERIODIC_CHANNELS && r.route[i][`ROUTE_PERIODIC])
               hwreq[i] = trig_rise[2'(i)];
            else
               hwreq[i] = r.slot_s2[slot];
         end
      end
      n.wake = |(r.slot_s2 & sel_slots & `ASYNC_SLOT_MASK);
      hwreq = hwreq & ~busy;
      // channel engine
      unique case (r.state)
         dma_controller_pkg::ST_IDLE:
         begin
            if (|(r.pending & ch_mask))
            begin
               n.ch = pick(r.pending & ch_mask, r.last, r.round_robin);
               n.last = n.ch;
               grab[n.ch] = 1'b1;
               n.left = r.desc[n.ch][`DESC_MINOR][15:0];
               n.idx = 3'h0;
               n.state = dma_controller_pkg::ST_READ;
            end
         end
         dma_controller_pkg::ST_READ:
         begin
            if (r.left < 16'h0004)
               n.state = dma_controller_pkg::ST_NEXT;
            else if (bus_ack && r.bus_req)
            begin
               n.bus_req = 1'b0;
               if (bus_err)
               begin
                  set_err[r.ch] = 1'b1;
                  n.state = dma_controller_pkg::ST_IDLE;
               end
               else
               begin
                  n.buffer[r.idx] = bus_rdata;
                  n.desc[r.ch][`DESC_SRC] = r.desc[r.ch][`DESC_SRC] + 32'h4;
                  n.left = r.left - 16'h0004;
                  n.idx = r.idx + 3'h1;
                  if (r.idx == 3'h7 || r.left < 16'h0008)
                  begin
                     n.cnt = {1'b0, r.idx} + 4'h1;
                     n.idx = 3'h0;
                     n.state = dma_controller_pkg::ST_WRITE;
                  end
               end
            end
            else if (!r.bus_req)
            begin
               n.bus_req = 1'b1;
               n.bus_write = 1'b0;
               n.bus_addr = r.desc[r.ch][`DESC_SRC];
            end
         end
         dma_controller_pkg::ST_WRITE:
         begin
            if (bus_ack && r.bus_req)
            begin
               n.bus_req = 1'b0;
               if (bus_err)
               begin
                  set_err[r.ch] = 1'b1;
                  n.state = dma_controller_pkg::ST_IDLE;
               end
               else
               begin
                  n.desc[r.ch][`DESC_DST] = r.desc[r.ch][`DESC_DST] + 32'h4;
                  n.idx = r.idx + 3'h1;
                  if ({1'b0, r.idx} + 4'h1 == r.cnt)
                  begin
                     n.idx = 3'h0;
                     n.state = (r.left < 16'h0004) ? dma_controller_pkg::ST_NEXT : dma_controller_pkg::ST_READ;
                  end
               end
            end
            else if (!r.bus_req)
            begin
               n.bus_req = 1'b1;
               n.bus_write = 1'b1;
               n.bus_addr = r.desc[r.ch][`DESC_DST];
               n.bus_wdata = r.buffer[r.idx];
            end
         end
         dma_controller_pkg::ST_NEXT:
         begin
            n.state = dma_controller_pkg::ST_IDLE;
            if (ctl[`CTRL_LINK_EN])
               link[ctl[7:4]] = 1'b1;
            if (r.desc[r.ch][`DESC_ITER][15:0] <= 16'h0001)
            begin
               set_done[r.ch] = 1'b1;
               n.desc[r.ch][`DESC_ITER][15:0] = r.desc[r.ch][`DESC_ITER][31:16];
               if (ctl[`CTRL_SG_EN])
               begin
                  n.idx = 3'h0;
                  n.state = dma_controller_pkg::ST_SG;
               end
            end
            else
               n.desc[r.ch][`DESC_ITER][15:0] = r.desc[r.ch][`DESC_ITER][15:0] - 16'h0001;
         end
         dma_controller_pkg::ST_SG:
         begin
            if (bus_ack && r.bus_req)
            begin
               n.bus_req = 1'b0;
               if (bus_err)
               begin
                  set_err[r.ch] = 1'b1;
                  n.state = dma_controller_pkg::ST_IDLE;
               end
               else
               begin
                  n.buffer[r.idx] = bus_rdata;
                  n.idx = r.idx + 3'h1;
                  if (r.idx == 3'h7)
                  begin
                     // whole descriptor replaced only after the last word
                     for (int k = 0; k < `DESC_WORDS - 1; k++)
                        n.desc[r.ch][k] = r.buffer[k];
                     n.desc[r.ch][7] = bus_rdata;
                     n.state = dma_controller_pkg::ST_IDLE;
                  end
               end
            end
            else if (!r.bus_req)
            begin
               n.bus_req = 1'b1;
               n.bus_write = 1'b0;
               n.bus_addr = r.desc[r.ch][`DESC_SG] + {27'h0, r.idx, 2'h0};
            end
         end
         default:
         begin
            n.state = dma_controller_pkg::ST_IDLE;
            n.bus_req = 1'b0;
         end
      endcase
      // routing change aborts the running channel
      if (r.state != dma_controller_pkg::ST_IDLE && rst[r.ch])
      begin
         n.state = dma_controller_pkg::ST_IDLE;
         n.bus_req = 1'b0;
      end
      n.pending = ((r.pending & ~grab) | start | hwreq | link) & ~rst & ch_mask;
      n.done = (r.done & ~clr_done) | set_done;
      n.err = (r.err & ~clr_err) | set_err;
      for (int i = 0; i < `CH_COUNT; i++)
      begin
         n.ch_irq[i] = n.done[i] & r.desc[i][`DESC_CTRL][`CTRL_INT_MAJOR];
         w[0] = w[0] | (n.err[i] & r.desc[i][`DESC_CTRL][`CTRL_ERR_EN]);
      end
      n.err_irq = w[0];
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         r <= '0;
      else
         r <= n;
   end

   assign reg_rdata = r.rdata;
   assign bus_req = r.bus_req;
   assign bus_write = r.bus_write;
   assign bus_addr = r.bus_addr;
   assign bus_wdata = r.bus_wdata;
   assign ch_irq = r.ch_irq;
   assign err_irq = r.err_irq;
   assign wake_req = r.wake;

   // ==========================================================
   // checks
   chk_write_after_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(r.bus_req) && r.bus_write |-> r.state == dma_controller_pkg::ST_WRITE && r.cnt != 4'h0)
      else $error("write issued without buffered read data");
   chk_req_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.bus_req && !bus_ack && !$rose(r.state == dma_controller_pkg::ST_IDLE) |=> r.bus_req && $stable(r.bus_addr)
         || r.state == dma_controller_pkg::ST_IDLE)
      else $error("bus request dropped before acknowledge");
   chk_buffer_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.cnt <= `BUF_WORDS)
      else $error("buffer fill exceeds eight words");
   chk_start_serve: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.state == dma_controller_pkg::ST_IDLE && |r.pending |=> r.state == dma_controller_pkg::ST_READ)
      else $error("pending channel not started");
   chk_link_pending: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.state == dma_controller_pkg::ST_NEXT && r.desc[r.ch][`DESC_CTRL][`CTRL_LINK_EN] && !reg_wr
         && ch_mask[r.desc[r.ch][`DESC_CTRL][7:4]]
      |=> r.pending[$past(r.desc[r.ch][`DESC_CTRL][7:4])])
      else $error("linked channel not made pending");
   chk_done_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.state == dma_controller_pkg::ST_NEXT && r.desc[r.ch][`DESC_ITER][15:0] <= 16'h0001
         && r.desc[r.ch][`DESC_CTRL][`CTRL_INT_MAJOR] && !reg_wr
      |=> r.done[r.ch] && ch_irq[r.ch])
      else $error("major completion did not raise channel interrupt");
   chk_err_term: assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.bus_req && bus_ack && bus_err && r.state != dma_controller_pkg::ST_IDLE
      |=> r.state == dma_controller_pkg::ST_IDLE && r.err[r.ch] && !r.bus_req)
      else $error("bus error did not terminate channel");
   chk_route_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_wr && reg_addr[11:6] == 6'h08 && reg_wdata[7:0] != r.route[reg_addr[5:2]]
      |=> !r.pending[$past(reg_addr[5:2])])
      else $error("routing change left channel pending");
   chk_reg_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
      reg_rd && reg_addr == `REG_CTRL |=> reg_rdata == {31'h0, $past(r.round_robin)})
      else $error("control readback mismatch");
endmodule
`default_nettype wire

// *** tb/bus_memory_model.sv ***
// crossbar memory model answering the dma bus master
`timescale 1ns/1ps
`default_nettype none
module bus_memory_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic bus_req,
   input wire logic bus_write,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic bus_ack,
   output logic bus_err,
   output logic [31:0] bus_rdata,
   input wire logic slow,
   input wire logic [31:0] err_addr
);
   logic [31:0] mem [logic [31:0]];
   int wait_cnt;
   // ack after zero or four wait cycles; read data only valid with ack
   always @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         bus_ack <= 1'b0;
         bus_err <= 1'b0;
         bus_rdata <= 32'h5a5a_a5a5;
         wait_cnt <= 0;
      end
      else if (bus_req && !bus_ack && wait_cnt >= (slow ? 4 : 0))
      begin
         bus_ack <= 1'b1;
         bus_err <= (bus_addr == err_addr);
         wait_cnt <= 0;
         if (bus_write && bus_addr != err_addr)
            mem[bus_addr] = bus_wdata;
         bus_rdata <= mem.exists(bus_addr) ? mem[bus_addr] : ~bus_addr;
      end
      else
      begin
         bus_ack <= 1'b0;
         bus_err <= 1'b0;
         // stale data must not look valid outside the ack cycle
         bus_rdata <= ~bus_rdata;
         wait_cnt <= bus_req ? wait_cnt + 1 : 0;
      end
   end
endmodule
`default_nettype wire

// *** tb/multichannel_dma_with_request_router_tb.sv ***
// self-checking testbench of the dma controller and request router
`timescale 1ns/1ps
`default_nettype none
module multichannel_dma_with_request_router_tb;
   logic ref_clk, reset_n, reg_wr, reg_rd, bus_req, bus_write, bus_ack, bus_err;
   logic err_irq, wake_req, slow;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata, err_addr, v;
   logic [63:0] slot_req;
   logic [3:0] periodic_trig;
   logic [15:0] ch_irq;
   int bad_count = 0;
   int comparisons = 0;
   dma_controller #(.small_inst(1'b0)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_req(slot_req),
      .periodic_trig(periodic_trig), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .ch_irq(ch_irq),
      .err_irq(err_irq), .wake_req(wake_req));
   bus_memory_model model (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata),
      .slow(slow), .err_addr(err_addr));
   // ==========================================
   // bus tasks and checks
   task automatic wrap_up();
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_bit(input logic [11:0] a, input int b);
      int n;
      n = 0;
      v = 32'h0;
      while (v[b] !== 1'b1 && n < 300)
      begin
         rd(a, v);
         n++;
      end
      check({31'h0, v[b]}, 32'h1);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      v = 32'hffff_ffff;
      while ((v[20] !== 1'b0 || v[15:0] !== 16'h0) && n < 300)
      begin
         rd(12'h310, v);
         n++;
      end
      check({15'h0, v[20], v[15:0]}, 32'h0);
   endtask
   task automatic prog(input int ch, input logic [31:0] src, input logic [31:0] dst, input logic [15:0] minor,
      input logic [15:0] iter, input logic [31:0] ctrl);
      logic [11:0] b;
      b = 12'(ch * 32);
      wr(b, src);
      wr(b + 12'h4, dst);
      wr(b + 12'h8, {16'h0, minor});
      wr(b + 12'hc, {iter, iter});
      wr(b + 12'h10, ctrl);
      for (int i = 0; i < 8; i++)
         model.mem[src + 32'(4 * i)] = src ^ 32'(i);
   endtask
   task automatic check_dst(input logic [31:0] src, input logic [31:0] dst, input int n);
      for (int i = 0; i < n; i++)
         check(model.mem.exists(dst + 32'(4 * i)) ? model.mem[dst + 32'(4 * i)] : 32'hx, src ^ 32'(i));
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      check({14'h0, ch_irq, err_irq, wake_req}, 32'h0);
      rd(12'h310, v);
      check(v, 32'h0);
      wr(12'h400, 32'hffff_ffff);
      rd(12'h400, v);
      check(v, 32'h0);
   endtask
   task automatic t_soft();
      prog(0, 32'h1000, 32'h2000, 16'h20, 16'h1, 32'h1);
      wr(12'h304, 32'h1);
      wait_bit(12'h308, 0);
      check_dst(32'h1000, 32'h2000, 8);
      check({16'h0, ch_irq}, 32'h1);
      wr(12'h308, 32'h1);
      rd(12'h308, v);
      check({30'h0, v[0], ch_irq[0]}, 32'h0);
   endtask
   task automatic t_major();
      prog(1, 32'h1100, 32'h2100, 16'h4, 16'h2, 32'h1);
      wr(12'h304, 32'h2);
      wait_idle();
      rd(12'h308, v);
      check({31'h0, v[1]}, 32'h0);
      check_dst(32'h1100, 32'h2100, 1);
      wr(12'h304, 32'h2);
      wait_bit(12'h308, 1);
      wr(12'h308, 32'h2);
   endtask
   task automatic t_link();
      prog(3, 32'h1300, 32'h2300, 16'h8, 16'h1, 32'h0);
      prog(2, 32'h1200, 32'h2200, 16'h8, 16'h1, 32'h32);
      wr(12'h304, 32'h4);
      wait_idle();
      check_dst(32'h1300, 32'h2300, 2);
      wr(12'h308, 32'hc);
   endtask
   task automatic t_hw();
      prog(4, 32'h1400, 32'h2400, 16'h8, 16'h1, 32'h0);
      wr(12'h210, 32'h85);
      slot_req[6] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(12'h310, v);
      check({31'h0, v[4]}, 32'h0);
      check({31'h0, wake_req}, 32'h0);
      slot_req[6] <= 1'b0;
      slot_req[5] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 check({31'h0, wake_req}, 32'h1);
      wait_bit(12'h308, 4);
      slot_req[5] <= 1'b0;
      wait_idle();
      check_dst(32'h1400, 32'h2400, 2);
      wr(12'h308, 32'h10);
   endtask
   task automatic t_periodic();
      prog(2, 32'h1500, 32'h2500, 16'h8, 16'h1, 32'h0);
      wr(12'h208, 32'hc0);
      periodic_trig[2] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      periodic_trig[2] <= 1'b0;
      wait_bit(12'h308, 2);
      wait_idle();
      check_dst(32'h1500, 32'h2500, 2);
      wr(12'h308, 32'h4);
   endtask
   task automatic t_prio_reroute();
      slow <= 1'b1;
      prog(0, 32'h1600, 32'h2600, 16'h20, 16'h1, 32'h0);
      prog(5, 32'h1700, 32'h2700, 16'h4, 16'h1, 32'h0);
      wr(12'h304, 32'h21);
      repeat (3) @(posedge ref_clk);
      rd(12'h310, v);
      check({26'h0, v[20:16], v[5]}, 32'h21);
      wr(12'h214, 32'h86);
      rd(12'h310, v);
      check({31'h0, v[5]}, 32'h0);
      wait_idle();
      slow <= 1'b0;
      rd(12'h308, v);
      check({30'h0, v[5], v[0]}, 32'h1);
      wr(12'h308, 32'h1);
   endtask
   task automatic t_error();
      err_addr <= 32'h1800;
      prog(7, 32'h1800, 32'h2800, 16'h8, 16'h1, 32'h201);
      wr(12'h304, 32'h80);
      wait_bit(12'h30c, 7);
      check({31'h0, err_irq}, 32'h1);
      rd(12'h308, v);
      check({31'h0, v[7]}, 32'h0);
      wr(12'h30c, 32'h80);
      rd(12'h30c, v);
      check({30'h0, v[7], err_irq}, 32'h0);
   endtask
   task automatic t_sg();
      prog(6, 32'h1b00, 32'h2b00, 16'h4, 16'h1, 32'h100);
      wr(12'hd4, 32'h3000);
      for (int i = 0; i < 8; i++)
         model.mem[32'h3000 + 32'(4 * i)] = 32'h0;
      model.mem[32'h3000] = 32'h1c00;
      model.mem[32'h3004] = 32'h2c00;
      model.mem[32'h3008] = 32'h4;
      model.mem[32'h300c] = 32'h0001_0001;
      model.mem[32'h1c00] = 32'h1c00;
      wr(12'h304, 32'h40);
      wait_idle();
      check_dst(32'h1b00, 32'h2b00, 1);
      rd(12'hc4, v);
      check(v, 32'h2c00);
      wr(12'h304, 32'h40);
      wait_idle();
      check_dst(32'h1c00, 32'h2c00, 1);
      wr(12'h308, 32'h40);
   endtask
   task automatic t_round_robin();
      wr(12'h300, 32'h1);
      rd(12'h300, v);
      check(v, 32'h1);
      prog(3, 32'h1900, 32'h2900, 16'h4, 16'h1, 32'h0);
      prog(8, 32'h1a00, 32'h2a00, 16'h4, 16'h1, 32'h0);
      wr(12'h304, 32'h108);
      rd(12'h310, v);
      check({26'h0, v[20:16], v[3]}, 32'h31);
      wait_idle();
      check_dst(32'h1900, 32'h2900, 1);
      check_dst(32'h1a00, 32'h2a00, 1);
      wr(12'h308, 32'h108);
   endtask
   // ==========================================
   // clock, reset, sequence and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      reset_n = 1'b0;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slot_req = 64'h0;
      periodic_trig = 4'h0;
      slow = 1'b0;
      err_addr = 32'hffff_fff0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_soft();
      t_major();
      t_link();
      t_hw();
      t_periodic();
      t_prio_reroute();
      t_error();
      t_sg();
      t_round_robin();
      wrap_up();
   end
   initial
   begin
      #400000;
      bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
